// ### hw/spc_sleep_power_controller.sv
`timescale 1ns/100ps
module spc_sleep_power_controller #(
  parameter logic [15:0] STARTUP_CYC = spc_pkg::SPC_STARTUP_RST,
  parameter int BOD_WAKE_CYC = spc_pkg::SPC_BOD_WAKE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core and system inputs (same clock)
  input wire logic sleep_instr_i,
  input wire logic wake_irq_i,
  input wire logic wake_reset_i,
  input wire logic crystal_clock_i,
  input wire logic debug_system_fuse_i,
  input wire logic debug_port_fuse_i,
  input wire logic brownout_level_fuse_i,
  input wire logic adc_enable_i,
  input wire logic comparator_off_i,
  input wire logic comparator_bandgap_i,
  input wire logic watchdog_enable_i,
  // Power control outputs
  output logic cpu_halt_o,
  output logic clk_cpu_en_o,
  output logic clk_io_en_o,
  output logic clk_adc_en_o,
  output logic main_osc_en_o,
  output logic [4:0] module_clk_en_o,
  output logic brownout_on_o,
  output logic comparator_en_o,
  output logic comparator_mux_en_o,
  output logic adc_on_o,
  output logic adc_extended_o,
  output logic reference_on_o,
  output logic watchdog_run_o,
  output logic input_buffer_en_o,
  output logic debug_port_en_o,
  output logic [2:0] sleep_mode_o
);
  import spc_pkg::*;

  typedef struct packed {
    logic [7:0] sleep_control;
    logic [7:0] mcu_control;
    logic [7:0] power_reduction;
    logic [2:0] unlock_cnt;
    logic [2:0] brownout_sleep_off_cnt;
    logic brownout_sleep_off_active;
    logic bod_off;
    logic [2:0] mode;
    spc_state_t state;
    logic [15:0] wait_cnt;
    logic adc_was_on;
    logic adc_extended;
    logic [31:0] dat;
    logic ack;
  } spc_regs_t;

  spc_regs_t state_reg;
  spc_regs_t state_next;

  // Valid mode codes; reserved ones refuse sleep
  function automatic logic spc_mode_valid(input logic [2:0] m);
    return (m == SPC_MODE_IDLE) || (m == SPC_MODE_ADC_NR) || (m == SPC_MODE_PDOWN) ||
      (m == SPC_MODE_PSAVE) || (m == SPC_MODE_STANDBY);
  endfunction

  // Modes where io and adc clocks both stop
  function automatic logic spc_mode_deep(input logic [2:0] m);
    return (m == SPC_MODE_PDOWN) || (m == SPC_MODE_PSAVE) || (m == SPC_MODE_STANDBY);
  endfunction

  logic wb_req;
  logic wr_mcu;
  logic sleeping;
  logic [2:0] sel_mode;
  logic [15:0] wake_cycles;

  assign wb_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign wr_mcu = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == SPC_ADDR_MCU_CONTROL);
  assign sleeping = (state_reg.state == SPC_ST_SLEEP);
  assign sel_mode = state_reg.sleep_control[SPC_SLEEP_SELECT_LSB +: 3];

  always_comb
  begin
    state_next = state_reg;
    state_next.ack = wb_req;
    state_next.dat = '0;
    wake_cycles = STARTUP_CYC;
    if (state_reg.mode == SPC_MODE_STANDBY)
    begin
      wake_cycles = {12'h000, SPC_STANDBY_WAKE} - {12'h000, SPC_WAKE_HALT};
    end
    if (state_reg.bod_off && (16'(BOD_WAKE_CYC) > wake_cycles))
    begin
      wake_cycles = 16'(BOD_WAKE_CYC);
    end
    // Unlock window countdown
    if (state_reg.unlock_cnt != 3'h0)
    begin
      state_next.unlock_cnt = state_reg.unlock_cnt - 3'h1;
    end
    // Brown-out sleep-off: delay then active, then self-clear
    if (state_reg.brownout_sleep_off_cnt != 3'h0)
    begin
      state_next.brownout_sleep_off_cnt = state_reg.brownout_sleep_off_cnt - 3'h1;
      if (!state_reg.brownout_sleep_off_active && state_reg.brownout_sleep_off_cnt == 3'h1)
      begin
        state_next.brownout_sleep_off_active = 1'b1;
        state_next.brownout_sleep_off_cnt = SPC_BROWNOUT_SLEEP_OFF_HOLD;
      end
      else if (state_reg.brownout_sleep_off_active && state_reg.brownout_sleep_off_cnt == 3'h1)
      begin
        state_next.brownout_sleep_off_active = 1'b0;
        state_next.mcu_control[SPC_BROWNOUT_SLEEP_OFF_BIT] = 1'b0;
      end
    end
    // Register writes
    if (wb_req && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        SPC_ADDR_SLEEP_CONTROL:
        begin
          state_next.sleep_control = {4'h0, wb_dat_i[3:0]};
        end
        SPC_ADDR_POWER_REDUCTION:
        begin
          state_next.power_reduction = wb_dat_i[7:0] & SPC_PRR_MASK;
        end
        default:
        begin
        end
      endcase
    end
    if (wr_mcu)
    begin
      state_next.mcu_control[SPC_DEBUG_OFF_BIT] = wb_dat_i[SPC_DEBUG_OFF_BIT];
      state_next.mcu_control[SPC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT] = 1'b0;
      if (wb_dat_i[SPC_BROWNOUT_SLEEP_OFF_BIT] && wb_dat_i[SPC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT])
      begin
        state_next.unlock_cnt = SPC_UNLOCK_WINDOW;
        state_next.mcu_control[SPC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT] = 1'b1;
      end
      else if (wb_dat_i[SPC_BROWNOUT_SLEEP_OFF_BIT] && state_reg.unlock_cnt != 3'h0)
      begin
        state_next.unlock_cnt = 3'h0;
        state_next.mcu_control[SPC_BROWNOUT_SLEEP_OFF_BIT] = 1'b1;
        state_next.brownout_sleep_off_active = 1'b0;
        state_next.brownout_sleep_off_cnt = SPC_BROWNOUT_SLEEP_OFF_DELAY;
      end
    end
    if (state_next.unlock_cnt == 3'h0)
    begin
      state_next.mcu_control[SPC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT] = 1'b0;
    end
    // Register reads; unmapped reads zero
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        SPC_ADDR_SLEEP_CONTROL: state_next.dat = {24'h0, state_reg.sleep_control};
        SPC_ADDR_MCU_CONTROL: state_next.dat = {24'h0, state_reg.mcu_control};
        SPC_ADDR_POWER_REDUCTION: state_next.dat = {24'h0, state_reg.power_reduction};
        SPC_ADDR_STATUS: state_next.dat = {24'h0, state_reg.adc_extended,
          state_reg.bod_off, state_reg.brownout_sleep_off_active, state_reg.mode, state_reg.state[1],
          state_reg.state[3] | state_reg.state[2]};
        default: state_next.dat = '0;
      endcase
    end
    // ADC off-then-on sets the extended flag, which then stays set until reset
    state_next.adc_was_on = adc_on_o;
    if (adc_on_o && !state_reg.adc_was_on)
    begin
      state_next.adc_extended = 1'b1;
    end
    // Sleep sequencer
    case (state_reg.state)
      SPC_ST_RUN:
      begin
        // Reserved code or disarmed: instruction is a no-op
        if (sleep_instr_i && state_reg.sleep_control[SPC_SLEEP_ARM_BIT] &&
          spc_mode_valid(sel_mode))
        begin
          state_next.state = SPC_ST_SLEEP;
          state_next.mode = sel_mode;
          state_next.bod_off = state_reg.brownout_sleep_off_active;
        end
      end
      SPC_ST_SLEEP:
      begin
        if (wake_irq_i || wake_reset_i)
        begin
          state_next.state = SPC_ST_START;
          state_next.wait_cnt = wake_cycles;
        end
      end
      SPC_ST_START:
      begin
        state_next.wait_cnt = state_reg.wait_cnt - 16'h0001;
        if (state_reg.wait_cnt <= 16'h0001)
        begin
          state_next.bod_off = 1'b0;
          state_next.state = SPC_ST_HALT;
          state_next.wait_cnt = {12'h000, SPC_WAKE_HALT};
        end
      end
      SPC_ST_HALT:
      begin
        state_next.wait_cnt = state_reg.wait_cnt - 16'h0001;
        if (state_reg.wait_cnt <= 16'h0001)
        begin
          state_next.state = SPC_ST_RUN;
        end
      end
      default:
      begin
        state_next.state = SPC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.sleep_control <= SPC_SLEEP_CONTROL_RST;
      state_reg.mcu_control <= SPC_MCU_CONTROL_RST;
      state_reg.power_reduction <= SPC_POWER_REDUCTION_RST;
      state_reg.state <= SPC_ST_RUN;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Power control outputs, registered from next state
  logic deep_next;
  logic asleep_next;
  logic [2:0] mode_next;
  assign asleep_next = (state_next.state != SPC_ST_RUN);
  assign mode_next = state_next.mode;
  assign deep_next = (state_next.state == SPC_ST_SLEEP) && spc_mode_deep(mode_next);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_halt_o <= 1'b0;
      clk_cpu_en_o <= 1'b1;
      clk_io_en_o <= 1'b1;
      clk_adc_en_o <= 1'b1;
      main_osc_en_o <= 1'b1;
      module_clk_en_o <= 5'h1f;
      brownout_on_o <= 1'b0;
      comparator_en_o <= 1'b0;
      comparator_mux_en_o <= 1'b0;
      adc_on_o <= 1'b0;
      adc_extended_o <= 1'b0;
      reference_on_o <= 1'b0;
      watchdog_run_o <= 1'b0;
      input_buffer_en_o <= 1'b1;
      debug_port_en_o <= 1'b0;
      sleep_mode_o <= SPC_MODE_IDLE;
    end
    else
    begin
      cpu_halt_o <= asleep_next;
      clk_cpu_en_o <= !asleep_next;
      clk_io_en_o <= !((state_next.state == SPC_ST_SLEEP) && (mode_next != SPC_MODE_IDLE));
      clk_adc_en_o <= !deep_next;
      // Debug fuse keeps oscillator alive; costs sleep current
      main_osc_en_o <= !(deep_next && mode_next != SPC_MODE_STANDBY &&
        !(debug_system_fuse_i && (mode_next == SPC_MODE_PDOWN ||
        mode_next == SPC_MODE_PSAVE)));
      // Gated modules freeze in place, so timer one resumes
      module_clk_en_o <= ~state_next.power_reduction[4:0];
      brownout_on_o <= brownout_level_fuse_i && !state_next.bod_off;
      comparator_en_o <= !comparator_off_i && (comparator_bandgap_i || !deep_next);
      comparator_mux_en_o <= !state_next.power_reduction[0];
      adc_on_o <= adc_enable_i && !state_next.power_reduction[0];
      adc_extended_o <= state_next.adc_extended;
      reference_on_o <= (brownout_level_fuse_i && !state_next.bod_off) ||
        (!comparator_off_i && comparator_bandgap_i) || adc_enable_i;
      watchdog_run_o <= watchdog_enable_i;
      // Wake-up pin buffers live outside this block
      input_buffer_en_o <= !deep_next;
      debug_port_en_o <= debug_port_fuse_i && !state_next.mcu_control[SPC_DEBUG_OFF_BIT];
      sleep_mode_o <= mode_next;
    end
  end

  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
endmodule

// ### include/spc_pkg.sv
package spc_pkg;
  // Wishbone word offsets (byte addresses)
  localparam logic [7:0] SPC_SLEEP_CONTROL_IDX = 8'h33;
  localparam logic [7:0] SPC_SLEEP_CONTROL_DATA = 8'h53;
  localparam logic [9:0] SPC_ADDR_SLEEP_CONTROL = 10'h0cc;
  localparam logic [9:0] SPC_ADDR_MCU_CONTROL = 10'h100;
  localparam logic [9:0] SPC_ADDR_POWER_REDUCTION = 10'h104;
  localparam logic [9:0] SPC_ADDR_STATUS = 10'h108;
  localparam logic [9:0] SPC_ADDR_COMMAND = 10'h10c;
  // Field positions
  localparam int SPC_SLEEP_ARM_BIT = 0;
  localparam int SPC_SLEEP_SELECT_LSB = 1;
  localparam int SPC_BROWNOUT_SLEEP_OFF_BIT = 6;
  localparam int SPC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT = 5;
  localparam int SPC_DEBUG_OFF_BIT = 7;
  localparam logic [7:0] SPC_PRR_MASK = 8'h1f;
  // Reset values
  localparam logic [7:0] SPC_SLEEP_CONTROL_RST = 8'h00;
  localparam logic [7:0] SPC_MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] SPC_POWER_REDUCTION_RST = 8'h00;
  // Sleep mode codes
  localparam logic [2:0] SPC_MODE_IDLE = 3'h0;
  localparam logic [2:0] SPC_MODE_ADC_NR = 3'h1;
  localparam logic [2:0] SPC_MODE_PDOWN = 3'h2;
  localparam logic [2:0] SPC_MODE_PSAVE = 3'h3;
  localparam logic [2:0] SPC_MODE_STANDBY = 3'h6;
  // Timing
  localparam logic [2:0] SPC_UNLOCK_WINDOW = 3'h4;
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_OFF_DELAY = 3'h3;
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_OFF_HOLD = 3'h3;
  localparam logic [3:0] SPC_WAKE_HALT = 4'h4;
  localparam logic [3:0] SPC_STANDBY_WAKE = 4'h6;
  localparam int SPC_CLK_HZ = 20000000;
  localparam int SPC_BOD_WAKE_US = 60;
  localparam int SPC_BOD_WAKE_CYC = SPC_BOD_WAKE_US * (SPC_CLK_HZ / 1000000);
  localparam logic [15:0] SPC_STARTUP_RST = 16'h0010;
  typedef enum logic [3:0] {
    SPC_ST_RUN = 4'b0001,
    SPC_ST_SLEEP = 4'b0010,
    SPC_ST_START = 4'b0100,
    SPC_ST_HALT = 4'b1000
  } spc_state_t;
endpackage

// ### tb/spc_chk_sva.sv
`timescale 1ns/100ps
module spc_chk (
  // Bus and core
  input logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, wake_irq_i, sleep_instr_i,
  input logic [31:0] wb_dat_o,
  // Fuses and peripherals
  input logic brownout_level_fuse_i, watchdog_enable_i,
  // Power outputs
  input logic cpu_halt_o, clk_io_en_o, clk_adc_en_o, brownout_on_o, comparator_mux_en_o,
  input logic watchdog_run_o, input_buffer_en_o,
  input logic [4:0] module_clk_en_o,
  input logic [2:0] sleep_mode_o
);
  import spc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_after_take: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_halt_cause: assert property ($rose(cpu_halt_o) |-> $past(sleep_instr_i))
    else $error("halt without sleep");
  // Start-up of at least two plus four halt cycles
  chk_wake_hold: assert property ($fell(cpu_halt_o) |-> $past(cpu_halt_o, 6))
    else $error("wake too short");
  chk_standby_wake: assert property ((cpu_halt_o && sleep_mode_o == SPC_MODE_STANDBY
    && $rose(wake_irq_i)) |-> ##[1:8] !cpu_halt_o)
    else $error("standby wake slow");
  chk_buffers_off: assert property ((!clk_io_en_o && !clk_adc_en_o) |-> !input_buffer_en_o)
    else $error("input buffers on");
  chk_mux_gated: assert property ((!module_clk_en_o[0] && !$past(module_clk_en_o[0]))
    |-> !comparator_mux_en_o)
    else $error("mux used while gated");
  chk_bod_restored: assert property ((!cpu_halt_o && brownout_level_fuse_i)[*3]
    |-> brownout_on_o)
    else $error("detector off while running");
  chk_watchdog_run: assert property (watchdog_enable_i[*3] |-> watchdog_run_o)
    else $error("watchdog stopped");
endmodule
bind spc_sleep_power_controller spc_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wake_irq_i, .sleep_instr_i, .wb_dat_o, .brownout_level_fuse_i,
  .watchdog_enable_i, .cpu_halt_o, .clk_io_en_o, .clk_adc_en_o, .brownout_on_o,
  .comparator_mux_en_o, .watchdog_run_o, .input_buffer_en_o, .module_clk_en_o, .sleep_mode_o);

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import spc_pkg::*;
  localparam logic [15:0] SU = 16'h0008;
  localparam int BW = 20;
  logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
  logic sleep_instr_i = '0, wake_irq_i = '0, wake_reset_i = '0, crystal_clock_i = '1;
  logic debug_system_fuse_i = '0, debug_port_fuse_i = '1, brownout_level_fuse_i = '0;
  logic adc_enable_i = '0, comparator_off_i = '0, comparator_bandgap_i = '0;
  logic watchdog_enable_i = '1;
  logic [9:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, cpu_halt_o, clk_cpu_en_o, clk_io_en_o, clk_adc_en_o, main_osc_en_o;
  logic brownout_on_o, comparator_en_o, comparator_mux_en_o, adc_on_o, adc_extended_o;
  logic reference_on_o, watchdog_run_o, input_buffer_en_o, debug_port_en_o;
  logic [4:0] module_clk_en_o;
  logic [2:0] sleep_mode_o;
  logic [7:0] q;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [2:0] resv [3] = '{3'h4, 3'h5, 3'h7};
  int failures = 0;
  int n_checks = 0;
  int n;
  spc_sleep_power_controller #(.STARTUP_CYC(SU), .BOD_WAKE_CYC(BW)) dut (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sleep_instr_i, .wake_irq_i, .wake_reset_i, .crystal_clock_i, .debug_system_fuse_i,
    .debug_port_fuse_i, .brownout_level_fuse_i, .adc_enable_i, .comparator_off_i,
    .comparator_bandgap_i, .watchdog_enable_i, .cpu_halt_o, .clk_cpu_en_o, .clk_io_en_o,
    .clk_adc_en_o, .main_osc_en_o, .module_clk_en_o, .brownout_on_o, .comparator_en_o,
    .comparator_mux_en_o, .adc_on_o, .adc_extended_o, .reference_on_o, .watchdog_run_o,
    .input_buffer_en_o, .debug_port_en_o, .sleep_mode_o);
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  task print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task timeout;
    failures++;
    print_verdict;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Ends one edge past ack so a following call never lands in the same step
  task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    q = wb_dat_o[7:0];
    if (k == 20) timeout;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rc(input logic [9:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task pulse;
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task slp(input logic [7:0] sc);
    wb(1'b1, SPC_ADDR_SLEEP_CONTROL, sc);
    pulse;
  endtask
  task wake(input logic rs);
    wake_irq_i <= !rs;
    wake_reset_i <= rs;
    for (n = 0; n < 300 && cpu_halt_o !== 1'b0; n++) @(posedge clk_i);
    if (n == 300) timeout;
    wake_irq_i <= 1'b0;
    wake_reset_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(SPC_ADDR_SLEEP_CONTROL, SPC_SLEEP_CONTROL_RST);
    rc(SPC_ADDR_MCU_CONTROL, SPC_MCU_CONTROL_RST);
    rc(SPC_ADDR_POWER_REDUCTION, SPC_POWER_REDUCTION_RST);
    rc(10'h3fc, 8'h00);
    chk(reference_on_o, 1'b0);
    adc_enable_i <= 1'b1;
    wb(1'b1, SPC_ADDR_SLEEP_CONTROL, 8'hff);
    rc(SPC_ADDR_SLEEP_CONTROL, 8'h0f);
    chk(reference_on_o, 1'b1);
    chk(adc_extended_o, 1'b1);
    adc_enable_i <= 1'b0;
    wb(1'b1, SPC_ADDR_POWER_REDUCTION, 8'hff);
    rc(SPC_ADDR_POWER_REDUCTION, 8'h1f);
    chk(module_clk_en_o, 5'h00);
    chk(comparator_mux_en_o, 1'b0);
    wb(1'b1, SPC_ADDR_POWER_REDUCTION, 8'h08);
    @(posedge clk_i);
    chk(module_clk_en_o, 5'h17);
    wb(1'b1, SPC_ADDR_POWER_REDUCTION, 8'h00);
    adc_enable_i <= 1'b1;
    slp(8'h04);
    chk(cpu_halt_o, 1'b0);
    foreach (resv[i])
    begin
      slp({4'h0, resv[i], 1'b1});
      chk(cpu_halt_o, 1'b0);
    end
    foreach (modes[i])
    begin
      debug_system_fuse_i <= (modes[i] == SPC_MODE_PSAVE);
      comparator_bandgap_i <= (modes[i] == SPC_MODE_STANDBY);
      slp({4'h0, modes[i], 1'b1});
      chk(cpu_halt_o, 1'b1);
      chk(sleep_mode_o, modes[i]);
      chk(clk_io_en_o, modes[i] == SPC_MODE_IDLE);
      chk(input_buffer_en_o, modes[i] < 3'h2);
      chk(main_osc_en_o, modes[i] != SPC_MODE_PDOWN);
      chk(comparator_en_o, modes[i] < 3'h2 || modes[i] == SPC_MODE_STANDBY);
      chk(adc_on_o, 1'b1);
      chk(watchdog_run_o, 1'b1);
      chk(clk_cpu_en_o, 1'b0);
      chk(clk_adc_en_o, modes[i] < 3'h2);
      rc(SPC_ADDR_STATUS, {3'h4, modes[i], 2'h2});
      wake(modes[i] == SPC_MODE_IDLE);
      chk(modes[i] == SPC_MODE_STANDBY ? n <= 8 : n >= SU + 4, 1'b1);
    end
    brownout_level_fuse_i <= 1'b1;
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h40);
    slp(8'h05);
    chk(brownout_on_o, 1'b1);
    wake(1'b0);
    wb(1'b1, SPC_ADDR_SLEEP_CONTROL, 8'h05);
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h60);
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h40);
    @(posedge clk_i);
    pulse;
    chk(brownout_on_o, 1'b0);
    wake(1'b0);
    chk(n >= BW, 1'b1);
    chk(brownout_on_o, 1'b1);
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h80);
    @(posedge clk_i);
    chk(debug_port_en_o, 1'b0);
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h00);
    @(posedge clk_i);
    chk(debug_port_en_o, 1'b1);
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h60);
    rc(SPC_ADDR_MCU_CONTROL, 8'h20);
    // Second step lands after the window has closed
    wb(1'b1, SPC_ADDR_MCU_CONTROL, 8'h40);
    rc(SPC_ADDR_MCU_CONTROL, 8'h00);
    print_verdict;
  end
endmodule
